// file: core/cdt_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "cdt_consts.svh"

// Overview of operation
// - Stop-on-receive set halts the timer on the first four frame bits.
// - Stop-on-receive is ignored while a trimming mode is selected.
// - Start field 00 starts only on the start command; 01 also starts when transmission ends.
// - Start 10/11 trim on oscillator edges; 11 underflows, 10 does not.
// - Auto-reload set: at zero reload from reload value and keep counting.
// - Auto-reload clear: count to zero then stop until next start.
// - Every underflow sets the underflow interrupt flag.
// - Select 00 counts carrier ticks; 01 counts the 211.875 kHz tick.
// - Clock select 10/11 count underflows of sibling timer zero or one.
// - Each start loads the counter from high and low reload bytes.
// - Reload writes do not disturb a running count; used at next start or auto-reload.
// - Live count readable as high byte at 21h and low byte at 22h.
module cdt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic carrier_tick,
  input wire logic tx_end,
  input wire logic rx_first_bits,
  input wire logic lfo_rise,
  input wire logic sibling_timer_zero_underflow,
  input wire logic sibling_timer_one_underflow,
  output logic underflow_pulse,
  output logic timer_running,
  output logic irq
);

  logic [7:0] control_q;
  logic [15:0] reload_value_q;
  logic [15:0] count_q;
  logic irq_status_q;
  logic irq_mask_q;
  logic underflow_d;
  logic div_tick;
  logic count_tick;
  logic start_evt;
  logic stop_evt;
  logic trimming;
  logic access;
  logic wr_en;
  logic mapped;
  logic [5:0] reg_idx;
  logic [31:0] rdata_d;
  cdt_pkg::cdt_state_e state_q;
  cdt_pkg::cdt_start_e start_sel;
  cdt_pkg::cdt_clk_e clk_sel;
  logic auto_reload_enable;
  logic stop_on_receive;
  logic sw_start;
  logic sw_stop;

  // Bus decode: one wait state, the answer comes from flip-flops
  assign access = psel && penable && !pready;
  assign reg_idx = paddr[7:2];
  assign wr_en = access && pwrite && pstrb[0];

  assign start_sel = cdt_pkg::cdt_start_e'(
    control_q[`CDT_CTL_START_HI:`CDT_CTL_START_LO]);
  assign clk_sel = cdt_pkg::cdt_clk_e'(
    control_q[`CDT_CTL_CLK_HI:`CDT_CTL_CLK_LO]);
  assign auto_reload_enable = control_q[`CDT_CTL_RELOAD_BIT];
  assign stop_on_receive = control_q[`CDT_CTL_STOP_RX_BIT];
  assign trimming = (start_sel == cdt_pkg::cdt_start_trim_hold) ||
                    (start_sel == cdt_pkg::cdt_start_trim_wrap);

  assign sw_start = wr_en && (reg_idx == `CDT_IDX_COMMAND) &&
                    pwdata[`CDT_CMD_START_BIT];
  assign sw_stop = wr_en && (reg_idx == `CDT_IDX_COMMAND) &&
                   pwdata[`CDT_CMD_STOP_BIT];

  cdt_tick_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .carrier_tick(carrier_tick),
    .div_tick(div_tick)
  );

  always_comb begin
    case (clk_sel)
      cdt_pkg::cdt_clk_carrier: count_tick = carrier_tick;
      cdt_pkg::cdt_clk_divided: count_tick = div_tick;
      cdt_pkg::cdt_clk_sibling0: begin
        count_tick = sibling_timer_zero_underflow;
      end
      cdt_pkg::cdt_clk_sibling1: begin
        count_tick = sibling_timer_one_underflow;
      end
      default: count_tick = 1'b0;
    endcase
  end

  // Start and stop events; in trimming an oscillator edge toggles the run
  always_comb begin
    start_evt = sw_start;
    stop_evt = sw_stop;
    case (start_sel)
      cdt_pkg::cdt_start_none: begin
        start_evt = sw_start;
      end
      cdt_pkg::cdt_start_tx_end: begin
        start_evt = sw_start || tx_end;
      end
      cdt_pkg::cdt_start_trim_hold,
      cdt_pkg::cdt_start_trim_wrap: begin
        start_evt = sw_start ||
                    (lfo_rise && (state_q == cdt_pkg::cdt_st_idle));
        stop_evt = sw_stop ||
                   (lfo_rise && (state_q == cdt_pkg::cdt_st_run));
      end
      default: begin
        start_evt = 1'b0;
        stop_evt = 1'b0;
      end
    endcase
    if (stop_on_receive && !trimming && rx_first_bits) begin
      stop_evt = 1'b1;
    end
  end

  // Underflow: a tick while the count stands at zero
  always_comb begin
    underflow_d = (state_q == cdt_pkg::cdt_st_run) && !stop_evt &&
                  !start_evt && count_tick && (count_q == 16'h0000) &&
                  (start_sel != cdt_pkg::cdt_start_trim_hold);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cdt_pkg::cdt_st_idle;
    end else if (stop_evt) begin
      state_q <= cdt_pkg::cdt_st_idle;
    end else if (start_evt) begin
      state_q <= cdt_pkg::cdt_st_run;
    end else if (underflow_d && !auto_reload_enable) begin
      state_q <= cdt_pkg::cdt_st_idle;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `CDT_COUNT_RESET;
    end else if (stop_evt) begin
      count_q <= count_q;
    end else if (start_evt) begin
      count_q <= reload_value_q;
    end else if (underflow_d && auto_reload_enable) begin
      count_q <= reload_value_q;
    end else if ((state_q == cdt_pkg::cdt_st_run) && count_tick &&
                 (count_q != 16'h0000)) begin
      count_q <= count_q - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_pulse <= 1'b0;
      timer_running <= 1'b0;
    end else begin
      underflow_pulse <= underflow_d;
      timer_running <= (state_q == cdt_pkg::cdt_st_run);
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= `CDT_CONTROL_RESET;
    end else if (wr_en && (reg_idx == `CDT_IDX_CONTROL)) begin
      control_q <= pwdata[7:0] & `CDT_CTL_WRITE_MASK;
    end
  end

  // Reload bytes only feed the counter at a start or reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_value_q <= `CDT_RELOAD_RESET;
    end else if (wr_en && (reg_idx == `CDT_IDX_RELOAD_HIGH)) begin
      reload_value_q[15:8] <= pwdata[7:0];
    end else if (wr_en && (reg_idx == `CDT_IDX_RELOAD_LOW)) begin
      reload_value_q[7:0] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= `CDT_IRQ_MASK_RESET;
    end else if (wr_en && (reg_idx == `CDT_IDX_IRQ_MASK)) begin
      irq_mask_q <= pwdata[`CDT_IRQ_UNDERFLOW_BIT];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 1'b0;
    end else if (underflow_d) begin
      irq_status_q <= 1'b1;
    end else if (wr_en && (reg_idx == `CDT_IDX_IRQ_STATUS) &&
                 pwdata[`CDT_IRQ_UNDERFLOW_BIT]) begin
      irq_status_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_status_q && irq_mask_q;
    end
  end

  // Read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    mapped = 1'b1;
    case (reg_idx)
      `CDT_IDX_CONTROL: rdata_d[7:0] = control_q;
      `CDT_IDX_RELOAD_HIGH: rdata_d[7:0] = reload_value_q[15:8];
      `CDT_IDX_RELOAD_LOW: rdata_d[7:0] = reload_value_q[7:0];
      `CDT_IDX_COUNT_HIGH: rdata_d[7:0] = count_q[15:8];
      `CDT_IDX_COUNT_LOW: rdata_d[7:0] = count_q[7:0];
      `CDT_IDX_IRQ_STATUS: rdata_d[0] = irq_status_q;
      `CDT_IDX_IRQ_MASK: rdata_d[0] = irq_mask_q;
      `CDT_IDX_COMMAND: rdata_d = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      if (access && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

endmodule : cdt_timer

`default_nettype wire

// file: core/cdt_consts.svh
`ifndef CDT_CONSTS_SVH
`define CDT_CONSTS_SVH

// Register indices; the APB byte address is four times the index
`define CDT_IDX_CONTROL 6'h1e
`define CDT_IDX_RELOAD_HIGH 6'h1f
`define CDT_IDX_RELOAD_LOW 6'h20
`define CDT_IDX_COUNT_HIGH 6'h21
`define CDT_IDX_COUNT_LOW 6'h22
`define CDT_IDX_IRQ_STATUS 6'h30
`define CDT_IDX_IRQ_MASK 6'h31
`define CDT_IDX_COMMAND 6'h32

// Control register fields
`define CDT_CTL_STOP_RX_BIT 7
`define CDT_CTL_START_HI 5
`define CDT_CTL_START_LO 4
`define CDT_CTL_RELOAD_BIT 3
`define CDT_CTL_CLK_HI 1
`define CDT_CTL_CLK_LO 0
`define CDT_CTL_WRITE_MASK 8'hbb

// Interrupt status and command fields
`define CDT_IRQ_UNDERFLOW_BIT 0
`define CDT_CMD_START_BIT 0
`define CDT_CMD_STOP_BIT 1

// Reset values
`define CDT_CONTROL_RESET 8'h00
`define CDT_RELOAD_RESET 16'h0000
`define CDT_COUNT_RESET 16'h0000
`define CDT_IRQ_MASK_RESET 1'b0

// Carrier is divided by 64 to give 211.875 kHz
`define CDT_CARRIER_DIV_LAST 6'h3f

`endif

// file: core/cdt_pkg.sv
package cdt_pkg;

  typedef enum logic [1:0] {
    cdt_start_none = 2'b00,
    cdt_start_tx_end = 2'b01,
    cdt_start_trim_hold = 2'b10,
    cdt_start_trim_wrap = 2'b11
  } cdt_start_e;

  typedef enum logic [1:0] {
    cdt_clk_carrier = 2'b00,
    cdt_clk_divided = 2'b01,
    cdt_clk_sibling0 = 2'b10,
    cdt_clk_sibling1 = 2'b11
  } cdt_clk_e;

  typedef enum logic [0:0] {
    cdt_st_idle = 1'b0,
    cdt_st_run = 1'b1
  } cdt_state_e;

endpackage : cdt_pkg

// file: core/cdt_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
`include "cdt_consts.svh"

module cdt_tick_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic carrier_tick,
  output logic div_tick
);

  logic [5:0] div_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 6'h00;
    end else if (carrier_tick) begin
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_tick <= 1'b0;
    end else begin
      div_tick <= carrier_tick && (div_cnt_q == `CDT_CARRIER_DIV_LAST);
    end
  end

endmodule : cdt_tick_div

`default_nettype wire

// file: test/cdt_timer_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "cdt_consts.svh"
module cdt_timer_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic carrier_tick,
  input wire logic tx_end,
  input wire logic rx_first_bits,
  input wire logic lfo_rise,
  input wire logic sibling_timer_zero_underflow,
  input wire logic sibling_timer_one_underflow,
  input wire logic underflow_pulse,
  input wire logic timer_running,
  input wire logic irq
);
  logic [7:0] ctl_q;
  logic [5:0] idx;
  logic take;
  logic wtake;
  assign idx = paddr[7:2];
  assign take = psel && penable && !pready;
  assign wtake = take && pwrite;
  // Shadow of the control register as the bus sets it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 8'h00;
    end else if (wtake && pstrb[0] && idx == `CDT_IDX_CONTROL) begin
      ctl_q <= pwdata[7:0] & `CDT_CTL_WRITE_MASK;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_next_a: assert property (take |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  ctl_read_a: assert property (
    pready && !pwrite && idx == `CDT_IDX_CONTROL |-> prdata == {24'h0, ctl_q})
    else $error("control read wrong");
  count_read_a: assert property (
    pready && idx inside {`CDT_IDX_COUNT_HIGH, `CDT_IDX_COUNT_LOW}
    |-> !pslverr && prdata[31:8] == 24'h0) else $error("count read wrong");
  tx_start_a: assert property (
    tx_end && ctl_q[5:4] == 2'h1 && !rx_first_bits && !wtake
    |=> ##1 timer_running) else $error("no start at tx end");
  rx_stop_a: assert property (
    rx_first_bits && ctl_q[7] && !ctl_q[5] |=> ##1 !timer_running)
    else $error("no stop on receive");
  irq_cause_a: assert property (
    $rose(irq) |-> $past(underflow_pulse) || $past(wtake, 2))
    else $error("irq without cause");
  trim_hold_a: assert property (
    underflow_pulse |-> $past(ctl_q[5:4]) != 2'h2)
    else $error("underflow in trim hold");
  pulse_running_a: assert property (
    underflow_pulse |-> timer_running) else $error("underflow while idle");
endmodule : cdt_timer_monitor
bind cdt_timer cdt_timer_monitor cdt_timer_monitor_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .carrier_tick, .tx_end, .rx_first_bits, .lfo_rise,
  .sibling_timer_zero_underflow, .sibling_timer_one_underflow,
  .underflow_pulse, .timer_running, .irq);
`default_nettype wire

// file: test/cascadable_countdown_timer_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch %0t: %h not %h", $time, a, b); end end
module cascadable_countdown_timer_test;
  logic pclk, presetn, psel, penable, pwrite, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic carrier_tick, tx_end, rx_first_bits, lfo_rise, sib0, sib1;
  logic pready, pslverr, underflow_pulse, timer_running, irq;
  int err_count, n_tests;
  cdt_timer cdt_timer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .carrier_tick, .tx_end,
    .rx_first_bits, .lfo_rise, .sibling_timer_zero_underflow(sib0),
    .sibling_timer_one_underflow(sib1), .underflow_pulse, .timer_running,
    .irq);
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task xfer(input logic w, input logic [5:0] i, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    pwdata <= {24'h0, prdata[7:0]};
    perr = pslverr;
    if (!w) `CHK(prdata, {24'h0, d})
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask : xfer
  task wr(input logic [5:0] i, input logic [7:0] d);
    xfer(1'h1, i, d);
  endtask : wr
  // Pulses: 0 carrier, 1 tx end, 2 rx bits, 3 lfo, 4/5 siblings
  task pulse(input int s, input int n);
    repeat (n) begin
      @(posedge pclk);
      {carrier_tick, tx_end, rx_first_bits, lfo_rise, sib0, sib1} <=
        6'h20 >> s;
      @(posedge pclk);
      {carrier_tick, tx_end, rx_first_bits, lfo_rise, sib0, sib1} <= 6'h00;
    end
    repeat (3) @(posedge pclk);
  endtask : pulse
  task test_done;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    {carrier_tick, tx_end, rx_first_bits, lfo_rise, sib0, sib1} = 6'h00;
    pstrb = 4'hf;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    xfer(1'h0, 6'h1e, 8'h00);
    wr(6'h1e, 8'hff);
    xfer(1'h0, 6'h1e, 8'hbb);
    wr(6'h21, 8'hff);
    xfer(1'h0, 6'h21, 8'h00);
    pstrb <= 4'he;
    wr(6'h20, 8'h55);
    pstrb <= 4'hf;
    xfer(1'h0, 6'h20, 8'h00);
    xfer(1'h0, 6'h10, 8'h00);
    `CHK(perr, 1'h1)
    $display("registers done");
    wr(6'h1e, 8'h00);
    wr(6'h31, 8'h01);
    wr(6'h20, 8'h02);
    wr(6'h32, 8'h01);
    xfer(1'h0, 6'h22, 8'h02);
    pulse(0, 3);
    `CHK(irq, 1'h1)
    `CHK(timer_running, 1'h0)
    xfer(1'h0, 6'h30, 8'h01);
    wr(6'h30, 8'h01);
    `CHK(irq, 1'h0)
    wr(6'h20, 8'h05);
    wr(6'h32, 8'h01);
    wr(6'h20, 8'h09);
    pulse(0, 1);
    xfer(1'h0, 6'h22, 8'h04);
    wr(6'h1f, 8'h12);
    wr(6'h32, 8'h01);
    xfer(1'h0, 6'h21, 8'h12);
    $display("one-shot done");
    wr(6'h31, 8'h00);
    wr(6'h1e, 8'h08);
    wr(6'h1f, 8'h00);
    wr(6'h20, 8'h01);
    wr(6'h32, 8'h01);
    pulse(0, 2);
    xfer(1'h0, 6'h22, 8'h01);
    `CHK({timer_running, irq}, 2'h2)
    wr(6'h20, 8'h05);
    for (int k = 0; k < 4; k++) begin
      wr(6'h1e, k[7:0]);
      wr(6'h32, 8'h01);
      pulse(k == 2 ? 5 : 4, 1);
      xfer(1'h0, 6'h22, 8'h05);
      pulse(k < 2 ? 0 : k + 2, k == 1 ? 64 : 1);
      xfer(1'h0, 6'h22, 8'h04);
    end
    $display("clocks done");
    wr(6'h32, 8'h02);
    pulse(1, 1);
    `CHK(timer_running, 1'h0)
    wr(6'h1e, 8'h90);
    pulse(1, 1);
    `CHK(timer_running, 1'h1)
    pulse(2, 1);
    pulse(0, 1);
    `CHK(timer_running, 1'h0)
    xfer(1'h0, 6'h22, 8'h05);
    wr(6'h1e, 8'hb0);
    pulse(3, 1);
    pulse(2, 1);
    `CHK(timer_running, 1'h1)
    pulse(3, 1);
    `CHK(timer_running, 1'h0)
    wr(6'h20, 8'h00);
    wr(6'h30, 8'h01);
    wr(6'h1e, 8'h20);
    pulse(3, 1);
    pulse(0, 3);
    `CHK(timer_running, 1'h1)
    xfer(1'h0, 6'h30, 8'h00);
    pulse(3, 1);
    wr(6'h1e, 8'h30);
    pulse(3, 1);
    pulse(0, 1);
    xfer(1'h0, 6'h30, 8'h01);
    $display("start modes done");
    test_done();
  end
endmodule : cascadable_countdown_timer_test
`default_nettype wire
